// ===== rtl/priority_pin_crossbar.sv
// Priority pin crossbar with port registers on a classic Wishbone slave
// Contract
// RULE1: Seventeen pins: two bytes plus one pin
// RULE2: Only the two byte ports are routable
// RULE3: Port read returns pin level, any routing
// RULE4: Priority order, each gets lowest free pin
// RULE5: Serial transmit pin 4, receive pin 5
// RULE6: Skipped pins treated like taken pins
// RULE7: Two-wire bus and serial port claim two
// RULE8: Leftover pins stay general-purpose port pins
// RULE9: Select line gets a pin only 4-wire
// RULE10: Software skips pins used outside the crossbar
// RULE11: Software enables the matrix last
// RULE12: Analog pin: no pullup, driver, receiver
// RULE13: Input kind one is digital; reset digital
// RULE14: Drive type applies to routed pins too
// RULE15: Two-wire bus pins always open-drain
// RULE16: Pullups on open-drain unless globally disabled
// RULE17: Pullup off while pin drives low
// RULE18: Matrix disabled: inputs only, drivers off
// RULE19: Software skips analog input pins
// RULE20: Analog pins read zero, digital read level
// RULE21: Latch readback for read-modify-write
// RULE22: Routed pin from function, else latch
//
// Chosen here: the Wishbone slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module priority_pin_crossbar
    import pin_matrix_pkg::*;
(
    input  wire logic                 core_clk,
    input  wire logic                 rst_n,
    // Wishbone slave
    input  wire logic                 cyc_i,
    input  wire logic                 stb_i,
    input  wire logic                 we_i,
    input  wire logic [ADR_W-1:0]     adr_i,
    input  wire logic [3:0]           sel_i,
    input  wire logic [31:0]          dat_i,
    output logic      [31:0]          dat_o,
    output logic                      ack_o,
    // Pins
    input  wire logic [NUM_PINS-1:0]  pin_in,
    output logic      [NUM_PINS-1:0]  pin_out,
    output logic      [NUM_PINS-1:0]  pin_oe,
    output logic      [NUM_PINS-1:0]  pin_pull,
    output logic      [NUM_PINS-1:0]  pin_rx_en,
    // Peripheral side
    input  wire logic                 serial_transmit_out,
    output logic                      serial_receive_in,
    input  wire logic [NUM_FUNCS-1:0] func_val,
    input  wire logic [NUM_FUNCS-1:0] func_oe,
    output logic      [NUM_FUNCS-1:0] func_in,
    output logic      [NUM_FUNCS-1:0] func_routed
);

    ////////////////////////////////////////////////////////////////////////////////
    // Register state
    logic [NUM_PINS-1:0]   port_latch;
    logic [NUM_PINS-1:0]   pin_input_kind;
    logic [NUM_PINS-1:0]   pin_drive_type;
    logic [ROUTE_PINS-1:0] pin_skip_mask;
    logic [7:0]            route_select_low;
    logic [7:0]            route_select_high;
    logic [1:0]            slave_select_mode;
    logic [NUM_PINS-1:0]   next_port_latch;
    logic [NUM_PINS-1:0]   next_pin_input_kind;
    logic [NUM_PINS-1:0]   next_pin_drive_type;
    logic [ROUTE_PINS-1:0] next_pin_skip_mask;
    logic [7:0]            next_route_select_low;
    logic [7:0]            next_route_select_high;
    logic [1:0]            next_slave_select_mode;
    logic [31:0]           next_dat_o;
    logic                  next_ack_o;
    logic                  req;
    logic                  wr;
    logic [7:0]            wbyte;
    logic [NUM_PINS-1:0]   pin_read;

    logic matrix_enable;
    logic weak_pull_disable;
    assign matrix_enable     = route_select_high[HI_XBAR];
    assign weak_pull_disable = route_select_high[HI_WPD];

    // Port reads: analog pins read zero, digital pins read the pin itself
    assign pin_read = pin_in & pin_input_kind;                       // [RULE3] [RULE20]

    // Bus decode, register writes and read mux
    always_comb begin
        req                    = cyc_i & stb_i & ~ack_o;
        wr                     = req & we_i & sel_i[0];
        wbyte                  = dat_i[7:0];
        next_ack_o             = req;
        next_dat_o             = 32'h0000_0000;
        next_port_latch        = port_latch;
        next_pin_input_kind    = pin_input_kind;
        next_pin_drive_type    = pin_drive_type;
        next_pin_skip_mask     = pin_skip_mask;
        next_route_select_low  = route_select_low;
        next_route_select_high = route_select_high;
        next_slave_select_mode = slave_select_mode;
        if (wr) begin
            unique case (adr_i)
                OFS_PORT0, OFS_LATCH0: next_port_latch[7:0]   = wbyte;
                OFS_PORT1, OFS_LATCH1: next_port_latch[15:8]  = wbyte;
                OFS_PORT2, OFS_LATCH2: next_port_latch[16]    = wbyte[0];
                OFS_ROUTE_LO:  next_route_select_low  = {2'b00, wbyte[5:0]};
                OFS_ROUTE_HI:  next_route_select_high = {wbyte[7:3], 1'b0, wbyte[1:0]};
                OFS_KIND0:     next_pin_input_kind[7:0]  = wbyte;    // [RULE13]
                OFS_KIND1:     next_pin_input_kind[15:8] = wbyte;
                OFS_KIND2:     next_pin_input_kind[16]   = wbyte[0];
                OFS_DRIVE0:    next_pin_drive_type[7:0]  = wbyte;
                OFS_DRIVE1:    next_pin_drive_type[15:8] = wbyte;
                OFS_DRIVE2:    next_pin_drive_type[16]   = wbyte[0];
                OFS_SKIP0:     next_pin_skip_mask[7:0]   = wbyte;
                OFS_SKIP1:     next_pin_skip_mask[15:8]  = wbyte;
                OFS_SSEL_MODE: next_slave_select_mode    = wbyte[1:0];
                default: ;
            endcase
        end
        if (req && !we_i) begin
            unique case (adr_i)
                OFS_PORT0:     next_dat_o = {24'h00_0000, pin_read[7:0]};
                OFS_PORT1:     next_dat_o = {24'h00_0000, pin_read[15:8]};
                OFS_PORT2:     next_dat_o = {31'h0000_0000, pin_read[16]};
                OFS_LATCH0:    next_dat_o = {24'h00_0000, port_latch[7:0]};   // [RULE21]
                OFS_LATCH1:    next_dat_o = {24'h00_0000, port_latch[15:8]};  // [RULE21]
                OFS_LATCH2:    next_dat_o = {31'h0000_0000, port_latch[16]};  // [RULE21]
                OFS_ROUTE_LO:  next_dat_o = {24'h00_0000, route_select_low};
                OFS_ROUTE_HI:  next_dat_o = {24'h00_0000, route_select_high};
                OFS_KIND0:     next_dat_o = {24'h00_0000, pin_input_kind[7:0]};
                OFS_KIND1:     next_dat_o = {24'h00_0000, pin_input_kind[15:8]};
                OFS_KIND2:     next_dat_o = {31'h0000_0000, pin_input_kind[16]};
                OFS_DRIVE0:    next_dat_o = {24'h00_0000, pin_drive_type[7:0]};
                OFS_DRIVE1:    next_dat_o = {24'h00_0000, pin_drive_type[15:8]};
                OFS_DRIVE2:    next_dat_o = {31'h0000_0000, pin_drive_type[16]};
                OFS_SKIP0:     next_dat_o = {24'h00_0000, pin_skip_mask[7:0]};
                OFS_SKIP1:     next_dat_o = {24'h00_0000, pin_skip_mask[15:8]};
                OFS_SSEL_MODE: next_dat_o = {30'h0000_0000, slave_select_mode};
                default:       next_dat_o = 32'h0000_0000;
            endcase
        end
    end

    // Register bank; pins reset to digital inputs with latches high
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            port_latch        <= RST_LATCH;
            pin_input_kind    <= RST_KIND;                           // [RULE13]
            pin_drive_type    <= RST_DRIVE;
            pin_skip_mask     <= RST_SKIP;
            route_select_low  <= RST_ROUTE;
            route_select_high <= RST_ROUTE;
            slave_select_mode <= RST_SSM;
            dat_o             <= 32'h0000_0000;
            ack_o             <= 1'b0;
        end else begin
            port_latch        <= next_port_latch;
            pin_input_kind    <= next_pin_input_kind;
            pin_drive_type    <= next_pin_drive_type;
            pin_skip_mask     <= next_pin_skip_mask;
            route_select_low  <= next_route_select_low;
            route_select_high <= next_route_select_high;
            slave_select_mode <= next_slave_select_mode;
            dat_o             <= next_dat_o;
            ack_o             <= next_ack_o;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Priority allocation
    logic                  uart_en;
    logic [ROUTE_PINS-1:0] uart_mask;
    logic [NUM_FUNCS-1:0]  func_en;
    logic [ROUTE_PINS-1:0] taken [NUM_FUNCS+1];
    logic [ROUTE_PINS-1:0] grant [NUM_FUNCS];

    // Function enables in priority order
    always_comb begin
        uart_en                = route_select_low[LO_UART];
        uart_mask              = '0;
        uart_mask[UART_TX_PIN] = uart_en;                            // [RULE5] [RULE7]
        uart_mask[UART_RX_PIN] = uart_en;                            // [RULE7]
        func_en                = '0;
        func_en[F_SCK]  = route_select_low[LO_SPI];
        func_en[F_MISO] = route_select_low[LO_SPI];
        func_en[F_MOSI] = route_select_low[LO_SPI];
        func_en[F_SSEL] = route_select_low[LO_SPI]
                          & (slave_select_mode != SSM_THREE_WIRE);   // [RULE9]
        func_en[F_SDA]  = route_select_low[LO_SMB];                  // [RULE7]
        func_en[F_SCL]  = route_select_low[LO_SMB];                  // [RULE7]
        func_en[F_CMP]  = route_select_low[LO_CMP];
        func_en[F_CMPA] = route_select_low[LO_CMPA];
        func_en[F_SCLK] = route_select_low[LO_SCLK];
        func_en[F_CEX0] = route_select_high[HI_PCA0+1:HI_PCA0] != 2'h0;
        func_en[F_CEX1] = route_select_high[HI_PCA0+1];
        func_en[F_CEX2] = route_select_high[HI_PCA0+1:HI_PCA0] == 2'h3;
        func_en[F_ECI]  = route_select_high[HI_ECI];
        func_en[F_T0]   = route_select_high[HI_T0];
        func_en[F_T1]   = route_select_high[HI_T1];
    end

    // Skipped pins start out taken, the serial port pins too
    assign taken[0] = pin_skip_mask | uart_mask;                     // [RULE6] [RULE5]

    // Chain of pickers, one per function in priority order
    for (genvar k = 0; k < NUM_FUNCS; k++) begin : g_pick
        slot_pick u_pick (                                           // [RULE4] [RULE6]
            .taken_in  (taken[k]),
            .want      (func_en[k]),
            .grant     (grant[k]),
            .taken_out (taken[k+1])
        );
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Pin steering
    logic [NUM_PINS-1:0]  routed;
    logic [NUM_PINS-1:0]  route_val;
    logic [NUM_PINS-1:0]  route_oe;
    logic [NUM_PINS-1:0]  od_force;
    logic [NUM_PINS-1:0]  next_pin_out;
    logic [NUM_PINS-1:0]  next_pin_oe;
    logic [NUM_PINS-1:0]  next_pin_pull;
    logic [NUM_PINS-1:0]  next_pin_rx_en;
    logic [NUM_FUNCS-1:0] next_func_in;
    logic [NUM_FUNCS-1:0] next_func_routed;
    logic                 next_serial_receive_in;
    logic [NUM_PINS-1:0]  live_in;

    // Owner of each pin; the single-bit port is never routed
    always_comb begin
        routed    = '0;                                              // [RULE2]
        route_val = '0;
        route_oe  = '0;
        od_force  = '0;
        live_in   = pin_in & pin_input_kind & {NUM_PINS{matrix_enable}};
        for (int k = 0; k < NUM_FUNCS; k++) begin
            routed[ROUTE_PINS-1:0]    = routed[ROUTE_PINS-1:0] | grant[k];
            route_val[ROUTE_PINS-1:0] = route_val[ROUTE_PINS-1:0]
                                        | (grant[k] & {ROUTE_PINS{func_val[k]}});
            route_oe[ROUTE_PINS-1:0]  = route_oe[ROUTE_PINS-1:0]
                                        | (grant[k] & {ROUTE_PINS{func_oe[k]}});
        end
        od_force[ROUTE_PINS-1:0] = grant[F_SDA] | grant[F_SCL];      // [RULE15]
        if (uart_en) begin
            routed[UART_TX_PIN]    = 1'b1;                           // [RULE5]
            route_val[UART_TX_PIN] = serial_transmit_out;
            route_oe[UART_TX_PIN]  = 1'b1;
            routed[UART_RX_PIN]    = 1'b1;
            route_oe[UART_RX_PIN]  = 1'b0;
        end
        next_serial_receive_in = uart_en ? live_in[UART_RX_PIN] : 1'b1;
        for (int k = 0; k < NUM_FUNCS; k++) begin
            next_func_routed[k] = matrix_enable & (grant[k] != '0);
            next_func_in[k]     = |(grant[k] & live_in[ROUTE_PINS-1:0]);
        end
    end

    // One cell per pin; unrouted pins follow the latch
    for (genvar p = 0; p < NUM_PINS; p++) begin : g_cell
        pin_cell u_cell (                                            // [RULE1] [RULE8]
            .latch_bit         (port_latch[p]),
            .routed            (routed[p]),
            .func_val          (route_val[p]),
            .func_oe           (route_oe[p]),
            .force_od          (od_force[p]),
            .digital           (pin_input_kind[p]),
            .push_pull         (pin_drive_type[p]),
            .matrix_enable     (matrix_enable),
            .weak_pull_disable (weak_pull_disable),
            .next_out          (next_pin_out[p]),
            .next_oe           (next_pin_oe[p]),
            .next_pull         (next_pin_pull[p]),
            .next_rx           (next_pin_rx_en[p])
        );
    end

    // Registered pin and peripheral outputs
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_out           <= '0;
            pin_oe            <= '0;
            pin_pull          <= '0;
            pin_rx_en         <= '1;
            func_in           <= '0;
            func_routed       <= '0;
            serial_receive_in <= 1'b1;
        end else begin
            pin_out           <= next_pin_out;
            pin_oe            <= next_pin_oe;                        // [RULE18]
            pin_pull          <= next_pin_pull;
            pin_rx_en         <= next_pin_rx_en;
            func_in           <= next_func_in;
            func_routed       <= next_func_routed;
            serial_receive_in <= next_serial_receive_in;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    sequence s_wb_req;
        cyc_i && stb_i && !ack_o;
    endsequence
    sequence s_wb_done;
        ack_o ##1 !ack_o;
    endsequence

    wb_ack_timing_a: assert property (s_wb_req |=> s_wb_done)
        else $error("Wishbone ack not a single pulse one cycle after request");
    matrix_off_a: assert property (!matrix_enable |=> pin_oe == '0) // [RULE18]
        else $error("Driver enabled while matrix disabled");
    analog_pin_a: assert property (                              // [RULE12]
        ((pin_oe | pin_pull | pin_rx_en) & ~$past(pin_input_kind)) == '0)
        else $error("Analog pin not fully disconnected");
    uart_tx_fixed_a: assert property (                           // [RULE5]
        matrix_enable && uart_en && pin_input_kind[UART_TX_PIN]
        && pin_drive_type[UART_TX_PIN]
        |=> pin_oe[UART_TX_PIN] && pin_out[UART_TX_PIN] == $past(serial_transmit_out))
        else $error("Serial transmit not on its fixed pin");
    port2_unrouted_a: assert property (                          // [RULE2]
        matrix_enable && pin_input_kind[16] && pin_drive_type[16]
        |=> pin_oe[16] && pin_out[16] == $past(port_latch[16]))
        else $error("Single pin port not following its latch");
    pull_low_off_a: assert property ((pin_oe & ~pin_out & pin_pull) == '0) // [RULE17]
        else $error("Pullup on while pin drives low");
    smb_open_drain_a: assert property (                          // [RULE15]
        (pin_out[ROUTE_PINS-1:0]
         & $past(od_force[ROUTE_PINS-1:0])) == '0)
        else $error("Two-wire bus pin driven high");
    skip_respected_a: assert property (                          // [RULE6]
        (grant[F_SCK] & pin_skip_mask) == '0)
        else $error("Skipped pin granted");
    ssel_three_wire_a: assert property (                         // [RULE9]
        slave_select_mode == SSM_THREE_WIRE |-> grant[F_SSEL] == '0)
        else $error("Select line routed in 3-wire mode");
    lowest_pin_a: assert property (                              // [RULE4]
        func_en[F_SCK] && taken[0] != '1
        |-> grant[F_SCK] == (~taken[0] & (taken[0] + 16'h0001)))
        else $error("First function not on lowest free pin");
    read_port_a: assert property (                               // [RULE3] [RULE20]
        cyc_i && stb_i && !ack_o && !we_i && adr_i == OFS_PORT0
        |=> dat_o[7:0] == $past(pin_in[7:0] & pin_input_kind[7:0]))
        else $error("Port read not pin level");

endmodule // priority_pin_crossbar
`default_nettype wire

// ===== rtl/pin_matrix_pkg.sv
// Constants shared by the priority pin crossbar and its slot_pick helper
package pin_matrix_pkg;

    // Pin and function counts
    localparam int NUM_PINS   = 17;
    localparam int ROUTE_PINS = 16;
    localparam int NUM_FUNCS  = 15;
    localparam int ADR_W      = 8;

    // Fixed pins of the asynchronous serial port
    localparam int UART_TX_PIN = 4;
    localparam int UART_RX_PIN = 5;

    // Crossbar functions in priority order, after the serial port
    localparam int F_SCK  = 0;
    localparam int F_MISO = 1;
    localparam int F_MOSI = 2;
    localparam int F_SSEL = 3;
    localparam int F_SDA  = 4;
    localparam int F_SCL  = 5;
    localparam int F_CMP  = 6;
    localparam int F_CMPA = 7;
    localparam int F_SCLK = 8;
    localparam int F_CEX0 = 9;
    localparam int F_CEX1 = 10;
    localparam int F_CEX2 = 11;
    localparam int F_ECI  = 12;
    localparam int F_T0   = 13;
    localparam int F_T1   = 14;

    // Register byte offsets
    localparam logic [ADR_W-1:0] OFS_PORT0     = 8'h00;
    localparam logic [ADR_W-1:0] OFS_PORT1     = 8'h04;
    localparam logic [ADR_W-1:0] OFS_PORT2     = 8'h08;
    localparam logic [ADR_W-1:0] OFS_ROUTE_LO  = 8'h0C;
    localparam logic [ADR_W-1:0] OFS_ROUTE_HI  = 8'h10;
    localparam logic [ADR_W-1:0] OFS_KIND0     = 8'h14;
    localparam logic [ADR_W-1:0] OFS_KIND1     = 8'h18;
    localparam logic [ADR_W-1:0] OFS_KIND2     = 8'h1C;
    localparam logic [ADR_W-1:0] OFS_DRIVE0    = 8'h20;
    localparam logic [ADR_W-1:0] OFS_DRIVE1    = 8'h24;
    localparam logic [ADR_W-1:0] OFS_DRIVE2    = 8'h28;
    localparam logic [ADR_W-1:0] OFS_SKIP0     = 8'h2C;
    localparam logic [ADR_W-1:0] OFS_SKIP1     = 8'h30;
    localparam logic [ADR_W-1:0] OFS_SSEL_MODE = 8'h34;
    localparam logic [ADR_W-1:0] OFS_LATCH0    = 8'h38;
    localparam logic [ADR_W-1:0] OFS_LATCH1    = 8'h3C;
    localparam logic [ADR_W-1:0] OFS_LATCH2    = 8'h40;

    // Reset values
    localparam logic [16:0] RST_LATCH = 17'h1_FFFF;
    localparam logic [16:0] RST_KIND  = 17'h1_FFFF;
    localparam logic [16:0] RST_DRIVE = 17'h0_0000;
    localparam logic [15:0] RST_SKIP  = 16'h0000;
    localparam logic [7:0]  RST_ROUTE = 8'h00;
    localparam logic [1:0]  RST_SSM   = 2'h0;

    // Field positions in the route select registers
    localparam int LO_UART = 0;
    localparam int LO_SPI  = 1;
    localparam int LO_SMB  = 2;
    localparam int LO_SCLK = 3;
    localparam int LO_CMP  = 4;
    localparam int LO_CMPA = 5;
    localparam int HI_PCA0 = 0;
    localparam int HI_ECI  = 3;
    localparam int HI_T0   = 4;
    localparam int HI_T1   = 5;
    localparam int HI_XBAR = 6;
    localparam int HI_WPD  = 7;

    // Slave-select mode that leaves the select line off the pins
    localparam logic [1:0] SSM_THREE_WIRE = 2'h0;

endpackage

// ===== rtl/slot_pick.sv
// Grants the lowest free routable pin to one crossbar function
`timescale 1ns/1ps
`default_nettype none
module slot_pick
    import pin_matrix_pkg::*;
(
    input  wire logic [ROUTE_PINS-1:0] taken_in,
    input  wire logic                  want,
    output logic      [ROUTE_PINS-1:0] grant,
    output logic      [ROUTE_PINS-1:0] taken_out
);
    logic [ROUTE_PINS-1:0] free;

    // Lowest set bit of the free mask; nothing when all pins are gone
    always_comb begin
        free      = ~taken_in;
        grant     = want ? (free & (~free + 16'h0001)) : '0;
        taken_out = taken_in | grant;
    end
endmodule // slot_pick
`default_nettype wire

// ===== rtl/pin_cell.sv
// Driver, pullup and receiver decision for one port pin
`timescale 1ns/1ps
`default_nettype none
module pin_cell (
    input  wire logic latch_bit,
    input  wire logic routed,
    input  wire logic func_val,
    input  wire logic func_oe,
    input  wire logic force_od,
    input  wire logic digital,
    input  wire logic push_pull,
    input  wire logic matrix_enable,
    input  wire logic weak_pull_disable,
    output logic      next_out,
    output logic      next_oe,
    output logic      next_pull,
    output logic      next_rx
);
    logic val;
    logic want;
    logic open_drain;

    // Source select, drive type and gating
    always_comb begin
        val        = routed ? func_val : latch_bit;          // [RULE22]
        want       = routed ? func_oe : 1'b1;
        open_drain = force_od | ~push_pull;                  // [RULE14] [RULE15]
        next_out   = 1'b0;
        next_oe    = 1'b0;
        if (matrix_enable && digital) begin                  // [RULE18] [RULE12]
            if (open_drain) begin
                next_oe = want & ~val;
            end else begin
                next_out = val;
                next_oe  = want;
            end
        end
        // Pullup on open-drain digital pins unless weak_pull_disable is set, off while pulling low
        next_pull = digital & open_drain & ~weak_pull_disable
                    & ~(next_oe & ~next_out);                // [RULE16] [RULE17] [RULE12]
        next_rx   = digital;                                 // [RULE12]
    end
endmodule // pin_cell
`default_nettype wire

// ===== verif/pin_world.sv
// Partner model of the board: pins with weak pullups and outside levels
`timescale 1ns/1ps
`default_nettype none
module pin_world (
    input  wire logic [16:0] pin_out,
    input  wire logic [16:0] pin_oe,
    input  wire logic [16:0] pin_pull,
    input  wire logic [16:0] ext,
    output logic      [16:0] pin_in
);
    // Driven pin shows its driver, else pullup, else the outside pattern
    always_comb begin
        for (int i = 0; i < 17; i++) begin
            pin_in[i] = pin_oe[i] ? pin_out[i] : (pin_pull[i] | ext[i]);
        end
    end
endmodule // pin_world
`default_nettype wire

// ===== verif/priority_pin_crossbar_tb.sv
// Self-checking testbench of the priority pin crossbar
`timescale 1ns/1ps
`default_nettype none
module priority_pin_crossbar_tb
    import pin_matrix_pkg::*;
;
    logic core_clk = 0, rst_n = 0, cyc = 0, stb = 0, we = 0, tx = 0;
    logic [7:0] adr = 8'h00, q;
    logic [3:0] sel = 4'h1;
    logic [31:0] dat = 32'h0000_0000, dat_o;
    logic ack_o, rxi;
    logic [16:0] pin_in, pin_out, pin_oe, pin_pull, pin_rx_en;
    logic [16:0] ext = 17'h0_A5C3;
    logic [14:0] fval = 15'h7FFB, fin, frt;
    int fail_count = 0, samples_checked = 0;
    always #20 core_clk = ~core_clk;
    priority_pin_crossbar priority_pin_crossbar_inst (.core_clk(core_clk), .rst_n(rst_n),
        .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(dat),
        .dat_o(dat_o), .ack_o(ack_o), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
        .pin_pull(pin_pull), .pin_rx_en(pin_rx_en), .serial_transmit_out(tx),
        .serial_receive_in(rxi), .func_val(fval), .func_oe(fval), .func_in(fin),
        .func_routed(frt));
    pin_world pin_world_inst (.pin_out(pin_out), .pin_oe(pin_oe), .pin_pull(pin_pull),
        .ext(ext), .pin_in(pin_in));
    // Compare one value and count it
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask
    // One classic Wishbone cycle, waiting for the answer
    task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
        int n;
        n = 0;
        cyc <= 1; stb <= 1; we <= w; adr <= a; dat <= {24'h00_0000, d};
        do @(posedge core_clk); while (ack_o !== 1'b1 && ++n < 50);
        if (ack_o !== 1'b1) fail_count++;
        q = dat_o[7:0];
        cyc <= 0; stb <= 0; we <= 0;
        @(posedge core_clk);
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // Pullups off: port reads show outside levels, receivers stay on
    task automatic t_idle();
        wb(1, OFS_ROUTE_HI, 8'h80);
        chk("pull", 17'h0_0000, pin_pull);
        chk("rx", 17'h1_FFFF, pin_rx_en);
        wb(0, OFS_PORT0, 8'h00);
        chk("port0", 8'hC3, q);
    endtask
    // Priority placement with skipped pins, then 4-wire select
    task automatic t_route();
        wb(1, OFS_DRIVE0, 8'hFF);
        wb(1, OFS_DRIVE1, 8'hFF);
        wb(1, OFS_SKIP0, 8'h0C);
        wb(1, OFS_ROUTE_LO, 8'h03);
        chk("oe off", 17'h0_0000, pin_oe);
        wb(1, OFS_ROUTE_HI, 8'hC0);
        chk("routed", 15'h0007, frt);
        chk("tx pin", 3'b100, {pin_oe[4], pin_out[4], pin_oe[5]});
        chk("gpio", 4'b1100, {pin_oe[8], pin_out[8], pin_oe[6], pin_out[6]});
        chk("func in", 15'h0007, fin);
        chk("rx in", 1'b0, rxi);
        wb(1, OFS_SSEL_MODE, 8'h01);
        chk("routed4", 15'h000F, frt);
    endtask
    // Latch readback and analog pin gating
    task automatic t_latch_analog();
        wb(1, OFS_PORT1, 8'h5A);
        wb(0, OFS_LATCH1, 8'h00);
        chk("latch1", 8'h5A, q);
        wb(0, OFS_PORT1, 8'h00);
        chk("port1", 8'h5A, q);
        wb(1, OFS_SKIP0, 8'h8C);
        wb(1, OFS_KIND0, 8'h7F);
        chk("analog", 3'b000, {pin_oe[7], pin_pull[7], pin_rx_en[7]});
        wb(0, OFS_PORT0, 8'h00);
        chk("port0 b7", 1'b0, q[7]);
    endtask
    // Open-drain pins: two-wire bus pins released and pulled, single pin port low, then high in push-pull
    task automatic t_open_drain();
        wb(1, OFS_ROUTE_HI, 8'h40);
        wb(1, OFS_ROUTE_LO, 8'h04);
        chk("od pins", 4'b0011, {pin_oe[1:0], pin_pull[1:0]});
        wb(1, OFS_PORT2, 8'h00);
        chk("p2 low", 3'b100, {pin_oe[16], pin_out[16], pin_pull[16]});
        wb(1, OFS_DRIVE2, 8'h01);
        wb(1, OFS_PORT2, 8'h01);
        chk("p2 pp", 3'b110, {pin_oe[16], pin_out[16], pin_pull[16]});
    endtask
    initial begin
        repeat (12) @(posedge core_clk);
        rst_n <= 1;
        @(posedge core_clk);
        t_idle();
        t_route();
        t_latch_analog();
        t_open_drain();
        conclude();
    end
    // Watchdog against a hung bus
    initial begin
        repeat (5000) @(posedge core_clk);
        fail_count++;
        conclude();
    end
endmodule // priority_pin_crossbar_tb
`default_nettype wire
